// ===== rxb_bit_packer.sv
// Places received bits into bytes from a chosen start position.
`timescale 1ns/1ps
module rxb_bit_packer
  import rxb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [2:0] align,
  input  wire logic       keep,
  input  wire logic       bit_valid,
  input  wire logic       bit_val,
  input  wire logic       coll,
  output logic            byte_done,
  output logic [7:0]      byte_data,
  output logic [2:0]      fill,
  output logic [7:0]      bit_index,
  output logic [7:0]      part_data
);

  rxb_pack_t s_reg;
  rxb_pack_t s_next;
  logic      stored_bit;
  logic [7:0] merged;

  always_comb
  begin
    s_next = s_reg;
    // A bit after a collision is forced to zero unless values are kept. [RULE9]
    stored_bit = (s_reg.after_coll && !keep) ? 1'b0 : bit_val;
    merged = s_reg.acc;
    merged[s_reg.pos] = stored_bit;
    if (start)
    begin
      // First stored bit lands at the alignment position; the index starts there too. [RULE10] [RULE16]
      s_next.acc        = RXB_ZERO_BYTE;
      s_next.pos        = align;
      s_next.after_coll = 1'b0;
      s_next.cnt        = {5'h00, align};
    end
    else if (bit_valid)
    begin
      s_next.pos = s_reg.pos + 3'h1;
      s_next.acc = (s_reg.pos == RXB_POS_LAST) ? RXB_ZERO_BYTE : merged; // [RULE10]
      if (coll)
        s_next.after_coll = 1'b1;
      if (s_reg.cnt != RXB_CNT_MAX)
        s_next.cnt = s_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign byte_done = bit_valid && !start && (s_reg.pos == RXB_POS_LAST);
  assign byte_data = merged;
  assign fill      = s_reg.pos;
  assign bit_index = s_reg.cnt;
  assign part_data = s_reg.acc;

  zero_after_a : assert property (@(posedge clk) disable iff (!nrst)
    (bit_valid && !start && s_reg.after_coll && !keep) |=> (s_reg.acc[$past(s_reg.pos)] == 1'b0)
      || ($past(s_reg.pos) == RXB_POS_LAST))
    else $error("bit after collision not zeroed"); // [RULE9]

endmodule : rxb_bit_packer

// ===== rxb_card_model.sv
// Card-side model that drives receive events into the bank.
`timescale 1ns/1ps
module rxb_card_model
  import rxb_pkg::*;
(
  input  wire logic clk,
  output rxb_rx_ev_t rx
);
  initial rx = '0;
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // Start marker, then data bits LSB first; coll_at marks the colliding bit.
  task automatic send(input logic [15:0] bits, input int n, input int coll_at);
    rx.sof = 1'b1;
    step();
    rx.sof = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      rx.bit_valid = 1'b1;
      rx.bit_val   = bits[i];
      rx.coll      = (i == coll_at);
      step();
    end
    rx.bit_valid = 1'b0;
    rx.coll      = 1'b0;
    // The bit line is inverted once after the last data bit, so a stale bit is never reused.
    rx.bit_val   = ~rx.bit_val;
  endtask : send
  // Kind 0 ends the frame, 1 breaks framing, 2 reports a parity or CRC fault.
  task automatic ev(input int kind);
    rx.end_frame = (kind == 0);
    rx.framing   = (kind == 1);
    rx.integrity = (kind == 2);
    step();
    rx.end_frame = 1'b0;
    rx.framing   = 1'b0;
    rx.integrity = 1'b0;
    // One quiet edge so back-to-back events never rewrite a field in one step.
    step();
  endtask : ev
endmodule : rxb_card_model

// ===== rxb_pkg.sv
// Shared constants and types of the receive status and bit framing bank.
package rxb_pkg;

  localparam logic [7:0] RXB_OFS_STATUS  = 8'h0B;
  localparam logic [7:0] RXB_OFS_BITCTRL = 8'h0C;
  localparam logic [7:0] RXB_OFS_COLL    = 8'h0D;

  localparam int RXB_CRYPTO_BIT = 5;
  localparam int RXB_KEEP_BIT   = 7;
  localparam int RXB_ALIGN_LSB  = 4;
  localparam int RXB_COLLISION_AS_ERROR_BIT = 3;
  localparam int RXB_VALID_BIT  = 7;

  localparam logic [2:0] RXB_CODE_IDLE   = 3'h0;
  localparam logic [2:0] RXB_CODE_TRANSMIT_WAIT_STATE = 3'h1;
  localparam logic [2:0] RXB_CODE_TXING  = 3'h3;
  localparam logic [2:0] RXB_CODE_RECEIVE_WAIT_STATE = 3'h5;
  localparam logic [2:0] RXB_CODE_WDATA  = 3'h6;
  localparam logic [2:0] RXB_CODE_RXING  = 3'h7;

  localparam logic [2:0] RXB_POS_LAST   = 3'h7;
  localparam logic [2:0] RXB_ALIGN_BYTE = 3'h0;
  localparam logic [7:0] RXB_COLL_LIMIT = 8'h40;
  localparam logic [7:0] RXB_CNT_MAX    = 8'hFF;
  localparam logic [7:0] RXB_ZERO_BYTE  = 8'h00;

  typedef struct packed {
    logic receive;
    logic transceive;
    logic authenticate;
    logic auth_done;
    logic tx_done;
    logic stop;
  } rxb_cmd_t;

  typedef struct packed {
    logic sof;
    logic bit_valid;
    logic bit_val;
    logic coll;
    logic end_frame;
    logic framing;
    logic integrity;
  } rxb_rx_ev_t;

  typedef enum logic [2:0] {
    RXB_IDLE,
    RXB_TX_WAIT,
    RXB_TRANSMITTING,
    RXB_RX_WAIT,
    RXB_WAIT_DATA,
    RXB_RECEIVING
  } rxb_state_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [2:0] pos;
    logic       after_coll;
    logic [7:0] cnt;
  } rxb_pack_t;

endpackage : rxb_pkg

// ===== rxb_status_bank.sv
// Receive status, bit framing control and collision position registers.
`timescale 1ns/1ps
// How it works
// RULE1 - framing fault flags and stops reception
// RULE2 - framing fault drops the last received byte
// RULE3 - framing flag clears at receive start
// RULE4 - parity or CRC fault flags, reception continues
// RULE5 - integrity flag clears at receive start
// RULE6 - collision sets integrity flag when enabled
// RULE7 - crypto bit set by authenticate, host clears
// RULE8 - three-bit state code reports transceiver state
// RULE9 - zero bits after collision unless kept
// RULE10 - alignment sets first stored bit position
// RULE11 - zero alignment means byte-oriented reception
// RULE12 - last-bits field counts valid final bits
// RULE13 - decoder loads last-bits, cleared at start
// RULE14 - collision valid only for in-range position
// RULE15 - collision index covers first eight bytes
// RULE16 - alignment value included in collision index
// RULE17 - reserved bits read zero, writes ignored
module rxb_status_bank
  import rxb_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  input  wire rxb_cmd_t   CMD,
  input  wire rxb_rx_ev_t RX,
  output logic [7:0]      REG_RDATA,
  output logic            FIFO_WR,
  output logic [7:0]      FIFO_DATA,
  output logic            CRYPTO_ON,
  output logic [2:0]      STATE_CODE,
  output logic            FRAMING_FAULT,
  output logic            INTEGRITY_FAULT
);

  typedef struct packed {
    rxb_state_t st;
    logic       crypto;
    logic       framing;
    logic       integ;
    logic       keep;
    logic [2:0] align;
    logic       collision_as_error;
    logic [2:0] lastbits;
    logic       coll_seen;
    logic       coll_valid;
    logic [6:0] coll_pos;
    logic       pend_valid;
    logic [7:0] pend_data;
    logic       fifo_wr;
    logic [7:0] fifo_data;
    logic [7:0] rdata;
    logic [2:0] code;
  } rxb_bank_t;

  rxb_bank_t s_reg;
  rxb_bank_t s_next;

  logic       rx_start;
  logic       rx_bit;
  logic       byte_done;
  logic [7:0] byte_data;
  logic [2:0] fill;
  logic [7:0] bit_index;
  logic [7:0] part_data;
  logic       wr_status;
  logic       wr_ctrl;

  // Receive clears its status as the command is taken, transceive only on reaching wait for data.
  // Built from registered state so the packer start does not loop back through the next-state logic.
  assign rx_start  = ((s_reg.st == RXB_IDLE) && CMD.receive && !CMD.stop)
                  || ((s_reg.st == RXB_RX_WAIT) && !CMD.stop); // [RULE3] [RULE5]
  assign rx_bit    = (s_reg.st == RXB_RECEIVING) && RX.bit_valid;
  assign wr_status = REG_WR && (REG_ADDR == RXB_OFS_STATUS);
  assign wr_ctrl   = REG_WR && (REG_ADDR == RXB_OFS_BITCTRL);

  rxb_bit_packer i_rxb_bit_packer (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .start     (rx_start),
    .align     (s_reg.align),
    .keep      (s_reg.keep),
    .bit_valid (rx_bit),
    .bit_val   (RX.bit_val),
    .coll      (RX.coll),
    .byte_done (byte_done),
    .byte_data (byte_data),
    .fill      (fill),
    .bit_index (bit_index),
    .part_data (part_data)
  );

  function automatic logic [2:0] state_code(input rxb_state_t st);
    case (st)
      RXB_IDLE:         state_code = RXB_CODE_IDLE;
      RXB_TX_WAIT:      state_code = RXB_CODE_TRANSMIT_WAIT_STATE;
      RXB_TRANSMITTING: state_code = RXB_CODE_TXING;
      RXB_RX_WAIT:      state_code = RXB_CODE_RECEIVE_WAIT_STATE;
      RXB_WAIT_DATA:    state_code = RXB_CODE_WDATA;
      RXB_RECEIVING:    state_code = RXB_CODE_RXING;
      default:          state_code = RXB_CODE_IDLE;
    endcase
  endfunction : state_code

  always_comb
  begin
    s_next = s_reg;
    s_next.fifo_wr = 1'b0;

    case (s_reg.st)
      RXB_IDLE:
      begin
        if (CMD.receive)
          s_next.st = RXB_RX_WAIT;
        else if (CMD.transceive || CMD.authenticate)
          s_next.st = RXB_TX_WAIT;
      end
      RXB_TX_WAIT:      s_next.st = RXB_TRANSMITTING;
      RXB_TRANSMITTING: s_next.st = CMD.tx_done ? RXB_RX_WAIT : RXB_TRANSMITTING;
      RXB_RX_WAIT:      s_next.st = RXB_WAIT_DATA;
      RXB_WAIT_DATA:    s_next.st = RX.sof ? RXB_RECEIVING : RXB_WAIT_DATA;
      RXB_RECEIVING:
      begin
        if (RX.framing || RX.end_frame)
          s_next.st = RXB_IDLE; // [RULE1]
      end
      default:          s_next.st = RXB_IDLE;
    endcase
    if (CMD.stop)
      s_next.st = RXB_IDLE;

    // Flags and reception fields clear whenever a reception is started. [RULE3] [RULE5]
    if (rx_start)
    begin
      s_next.framing    = 1'b0;
      s_next.integ      = 1'b0;
      s_next.lastbits   = RXB_ALIGN_BYTE; // [RULE13]
      s_next.coll_seen  = 1'b0;
      s_next.coll_valid = 1'b0;
      s_next.coll_pos   = '0;
      s_next.pend_valid = 1'b0;
    end

    if (s_reg.st == RXB_RECEIVING)
    begin
      if (RX.framing)
        s_next.framing = 1'b1; // [RULE1]
      if (RX.integrity || (rx_bit && RX.coll && s_reg.collision_as_error))
        s_next.integ = 1'b1; // [RULE4] [RULE6]
      if (rx_bit && RX.coll && !s_reg.coll_seen)
      begin
        s_next.coll_seen = 1'b1;
        // Index already holds the alignment offset; beyond eight bytes it is not reported. [RULE14] [RULE15] [RULE16]
        if (bit_index < RXB_COLL_LIMIT)
        begin
          s_next.coll_valid = 1'b1;
          s_next.coll_pos   = bit_index[6:0];
        end
      end
      // A finished byte is held back until the next byte or frame end so a framing fault can still drop it.
      if (RX.framing)
        s_next.pend_valid = 1'b0; // [RULE2]
      else if (byte_done)
      begin
        s_next.fifo_wr    = s_reg.pend_valid;
        s_next.fifo_data  = s_reg.pend_data;
        s_next.pend_valid = 1'b1;
        s_next.pend_data  = byte_data;
      end
      else if (RX.end_frame)
      begin
        s_next.fifo_wr   = s_reg.pend_valid;
        s_next.fifo_data = s_reg.pend_data;
        // Bit-oriented frames also report and flush the partial final byte. [RULE11] [RULE12] [RULE13]
        if (s_reg.align != RXB_ALIGN_BYTE)
        begin
          s_next.lastbits   = fill;
          s_next.pend_valid = (fill != RXB_ALIGN_BYTE);
          s_next.pend_data  = part_data;
        end
        else
          s_next.pend_valid = 1'b0;
      end
    end
    else if (s_reg.pend_valid)
    begin
      s_next.fifo_wr    = 1'b1;
      s_next.fifo_data  = s_reg.pend_data;
      s_next.pend_valid = 1'b0;
    end

    // The host may only clear the crypto bit; an authentication finishing in the same cycle wins. [RULE7]
    if (wr_status && !REG_WDATA[RXB_CRYPTO_BIT])
      s_next.crypto = 1'b0;
    if (CMD.auth_done)
      s_next.crypto = 1'b1;

    if (wr_ctrl)
    begin
      s_next.keep     = REG_WDATA[RXB_KEEP_BIT];
      s_next.align    = REG_WDATA[RXB_ALIGN_LSB +: 3];
      s_next.collision_as_error   = REG_WDATA[RXB_COLLISION_AS_ERROR_BIT];
      s_next.lastbits = REG_WDATA[2:0];
    end

    s_next.code = state_code(s_next.st); // [RULE8]

    s_next.rdata = s_reg.rdata;
    if (REG_RD)
    begin
      case (REG_ADDR)
        RXB_OFS_STATUS:  s_next.rdata = {2'h0, s_reg.crypto, 2'h0, s_reg.code}; // [RULE17]
        RXB_OFS_BITCTRL: s_next.rdata = {s_reg.keep, s_reg.align, s_reg.collision_as_error, s_reg.lastbits};
        RXB_OFS_COLL:    s_next.rdata = {s_reg.coll_valid, s_reg.coll_pos};
        default:         s_next.rdata = RXB_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign REG_RDATA       = s_reg.rdata;
  assign FIFO_WR         = s_reg.fifo_wr;
  assign FIFO_DATA       = s_reg.fifo_data;
  assign CRYPTO_ON       = s_reg.crypto;
  assign STATE_CODE      = s_reg.code;
  assign FRAMING_FAULT   = s_reg.framing;
  assign INTEGRITY_FAULT = s_reg.integ;

  framing_stop_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (s_reg.st == RXB_RECEIVING && RX.framing && !CMD.stop) |=> (FRAMING_FAULT && STATE_CODE == RXB_CODE_IDLE))
    else $error("framing fault did not flag and stop"); // [RULE1]

  framing_drop_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (s_reg.st == RXB_RECEIVING && RX.framing) |=> !s_reg.pend_valid ##1 !FIFO_WR)
    else $error("byte kept after framing fault"); // [RULE2]

  flags_clear_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ($changed(s_reg.code) && s_reg.code == RXB_CODE_WDATA) |-> (!FRAMING_FAULT && !INTEGRITY_FAULT))
    else $error("fault flags not cleared at wait for data"); // [RULE3] [RULE5]

  integ_cont_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (s_reg.st == RXB_RECEIVING && RX.integrity && !RX.framing && !RX.end_frame && !CMD.stop)
      |=> (INTEGRITY_FAULT && STATE_CODE == RXB_CODE_RXING))
    else $error("integrity fault not flagged or reception stopped"); // [RULE4]

  coll_integ_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (rx_bit && RX.coll && s_reg.collision_as_error) |=> INTEGRITY_FAULT)
    else $error("collision did not set integrity flag"); // [RULE6]

  crypto_set_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ($rose(CRYPTO_ON) |-> $past(CMD.auth_done)) and (CMD.auth_done |=> CRYPTO_ON))
    else $error("crypto bit set without authentication"); // [RULE7]

  code_legal_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (STATE_CODE != 3'h4) && (STATE_CODE != 3'h2))
    else $error("unused state code reported"); // [RULE8]

  coll_range_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (rx_bit && RX.coll && !s_reg.coll_seen) |=> (s_reg.coll_valid == ($past(bit_index) < RXB_COLL_LIMIT)))
    else $error("collision valid bit wrong"); // [RULE14] [RULE15] [RULE16]

  lastbits_a : assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (s_reg.st == RXB_RECEIVING && RX.end_frame && !RX.framing && !byte_done && !wr_ctrl
      && s_reg.align != RXB_ALIGN_BYTE) |=> (s_reg.lastbits == $past(fill)))
    else $error("last bits not loaded at frame end"); // [RULE12] [RULE13]

endmodule : rxb_status_bank

// ===== test_contactless_rx_status_bank.sv
// Self-checking bench for the receive status and bit framing bank.
`timescale 1ns/1ps
module test_contactless_rx_status_bank
  import rxb_pkg::*;
;
  logic       sys_clk;
  logic       nrst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  rxb_cmd_t   cmd;
  rxb_rx_ev_t rx;
  logic [7:0] reg_rdata;
  logic       fifo_wr;
  logic [7:0] fifo_data;
  logic       crypto_on;
  logic [2:0] state_code;
  logic       framing_fault;
  logic       integrity_fault;
  logic [7:0] got_q[$];
  int         mismatches;
  int         checks_done;
  int         cycles;

  rxb_status_bank i_rxb_status_bank (.SYS_CLK(sys_clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .CMD(cmd), .RX(rx), .REG_RDATA(reg_rdata), .FIFO_WR(fifo_wr),
    .FIFO_DATA(fifo_data), .CRYPTO_ON(crypto_on), .STATE_CODE(state_code), .FRAMING_FAULT(framing_fault),
    .INTEGRITY_FAULT(integrity_fault));
  rxb_card_model i_rxb_card_model (.clk(sys_clk), .rx(rx));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 120 cycles; the ceiling of 5000 leaves wide margin.
  always @(posedge sys_clk)
  begin
    if (fifo_wr === 1'b1)
      got_q.push_back(fifo_data);
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic st(input logic [2:0] exp);
    chk("state code", {5'h00, exp}, {5'h00, state_code});
  endtask : st
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    cyc();
    reg_wr    = 1'b0;
    // An idle edge between accesses keeps a strobe from being lowered and raised in one step.
    cyc();
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    reg_rd   = 1'b1;
    reg_addr = a;
    cyc();
    reg_rd   = 1'b0;
    chk(name, exp, reg_rdata);
    cyc();
  endtask : rd_chk
  task automatic send_cmd(input logic [5:0] c);
    cmd = rxb_cmd_t'(c);
    cyc();
    cmd = '0;
  endtask : send_cmd
  task automatic expect_fifo(input logic [15:0] exp, input int n);
    chk("fifo count", 8'(n), 8'(got_q.size()));
    for (int i = 0; i < n && i < got_q.size(); i++)
      chk("fifo byte", exp[8*i +: 8], got_q[i]);
    got_q.delete();
  endtask : expect_fifo
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    cmd = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    rd_chk("status", RXB_OFS_STATUS, 8'h00);
    rd_chk("bit control", RXB_OFS_BITCTRL, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(RXB_OFS_COLL, 8'hFF);
    rd_chk("collision", RXB_OFS_COLL, 8'h00);
    $display("Test registers done");
    send_cmd(6'h20);
    st(RXB_CODE_RECEIVE_WAIT_STATE);
    cyc();
    st(RXB_CODE_WDATA);
    i_rxb_card_model.send(16'h00A5, 8, -1);
    st(RXB_CODE_RXING);
    i_rxb_card_model.ev(0);
    repeat (2) cyc();
    expect_fifo(16'h00A5, 1);
    st(RXB_CODE_IDLE);
    $display("Test byte frame done");
    wr(RXB_OFS_BITCTRL, 8'h48);
    send_cmd(6'h20);
    cyc();
    i_rxb_card_model.send(16'h0FFF, 11, 3);
    i_rxb_card_model.ev(0);
    repeat (3) cyc();
    expect_fifo(16'h00F0, 2);
    rd_chk("collision", RXB_OFS_COLL, 8'h87);
    chk("integrity", 8'h01, {7'h00, integrity_fault});
    rd_chk("bit control", RXB_OFS_BITCTRL, 8'h4F);
    $display("Test aligned collision done");
    wr(RXB_OFS_BITCTRL, 8'h83);
    send_cmd(6'h20);
    chk("integrity", 8'h00, {7'h00, integrity_fault});
    cyc();
    i_rxb_card_model.send(16'h003C, 8, 2);
    chk("integrity", 8'h00, {7'h00, integrity_fault});
    i_rxb_card_model.ev(2);
    chk("integrity", 8'h01, {7'h00, integrity_fault});
    st(RXB_CODE_RXING);
    i_rxb_card_model.ev(0);
    repeat (2) cyc();
    expect_fifo(16'h003C, 1);
    rd_chk("collision", RXB_OFS_COLL, 8'h82);
    rd_chk("bit control", RXB_OFS_BITCTRL, 8'h80);
    $display("Test integrity done");
    wr(RXB_OFS_BITCTRL, 8'h00);
    send_cmd(6'h20);
    cyc();
    i_rxb_card_model.send(16'h0FAA, 12, -1);
    i_rxb_card_model.ev(1);
    repeat (2) cyc();
    chk("framing", 8'h01, {7'h00, framing_fault});
    st(RXB_CODE_IDLE);
    expect_fifo(16'h0000, 0);
    send_cmd(6'h10);
    st(RXB_CODE_TRANSMIT_WAIT_STATE);
    cyc();
    st(RXB_CODE_TXING);
    chk("framing", 8'h01, {7'h00, framing_fault});
    send_cmd(6'h02);
    st(RXB_CODE_RECEIVE_WAIT_STATE);
    cyc();
    chk("framing", 8'h00, {7'h00, framing_fault});
    send_cmd(6'h01);
    st(RXB_CODE_IDLE);
    $display("Test framing done");
    send_cmd(6'h08);
    cyc();
    send_cmd(6'h02);
    cyc();
    chk("crypto", 8'h00, {7'h00, crypto_on});
    send_cmd(6'h04);
    chk("crypto", 8'h01, {7'h00, crypto_on});
    rd_chk("status", RXB_OFS_STATUS, 8'h26);
    send_cmd(6'h01);
    wr(RXB_OFS_STATUS, 8'hFF);
    rd_chk("status", RXB_OFS_STATUS, 8'h20);
    wr(RXB_OFS_STATUS, 8'h00);
    rd_chk("status", RXB_OFS_STATUS, 8'h00);
    chk("crypto", 8'h00, {7'h00, crypto_on});
    $display("Test crypto done");
    tally_and_finish();
  end
endmodule : test_contactless_rx_status_bank
